// File: transceiver_scan_pkg.sv
// Constants, opcodes and state types shared by the scan register block.
// Assumes one core clock; the test clock arrives as a sampled pin.
`default_nettype none

package transceiver_scan_pkg;
  localparam int IR_W = 8;
  localparam int OP_W = 7;
  localparam int BSR_W = 18;
  localparam int BCR_W = 2;
  localparam int PORT_W = 8;
  localparam int SYNC_W = 21;

  // Boundary chain field positions
  localparam int BIT_DIR = 17;
  localparam int BIT_OEN = 16;
  localparam int IN_HI = 15;
  localparam int IN_LO = 8;
  localparam int OUT_HI = 7;
  localparam int OUT_LO = 0;

  // Positions of the pins inside the synchroniser word
  localparam int SY_TCK = 20;
  localparam int SY_TMS = 19;
  localparam int SY_TDI = 18;
  localparam int SY_DIR = 17;
  localparam int SY_OEN = 16;
  localparam int SY_A_HI = 15;
  localparam int SY_A_LO = 8;
  localparam int SY_B_HI = 7;
  localparam int SY_B_LO = 0;

  // Reset and capture values
  localparam logic [IR_W-1:0] IR_RESET = 8'hFF;
  localparam logic [IR_W-1:0] IR_CAPTURE = 8'h81;
  localparam logic [BCR_W-1:0] BCR_RESET = 2'h2;
  localparam logic [BSR_W-1:0] BSR_RESET = 18'h00000;
  localparam logic BYPASS_CAPTURE = 1'b0;

  // Test operation selector codes
  localparam logic [BCR_W-1:0] BCR_TOPSIP = 2'h0;
  localparam logic [BCR_W-1:0] BCR_PATTERN_SOURCE = 2'h1;
  localparam logic [BCR_W-1:0] BCR_PSA = 2'h2;
  localparam logic [BCR_W-1:0] BCR_BOTH = 2'h3;

  // Lower seven opcode bits
  localparam logic [OP_W-1:0] OP_EXTEST = 7'h00;
  localparam logic [OP_W-1:0] OP_SAMPLE = 7'h02;
  localparam logic [OP_W-1:0] OP_INTEST = 7'h03;
  localparam logic [OP_W-1:0] OP_HIGHZ = 7'h06;
  localparam logic [OP_W-1:0] OP_CLAMP = 7'h07;
  localparam logic [OP_W-1:0] OP_SELF_RUN_OP = 7'h09;
  localparam logic [OP_W-1:0] OP_READN = 7'h0A;
  localparam logic [OP_W-1:0] OP_READT = 7'h0B;
  localparam logic [OP_W-1:0] OP_SELFTEST = 7'h0C;
  localparam logic [OP_W-1:0] OP_TOGGLE = 7'h0D;
  localparam logic [OP_W-1:0] OP_SCANN = 7'h0E;
  localparam logic [OP_W-1:0] OP_SCANT = 7'h0F;

  typedef enum {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } tap_state_t;

  typedef enum {SEL_BSR, SEL_BCR, SEL_BYP} dr_sel_t;
  typedef enum {MODE_NORMAL, MODE_TEST, MODE_MODTEST} op_mode_t;
endpackage : transceiver_scan_pkg

`default_nettype wire

// File: scan_pin_sync.sv
// Two-stage synchroniser for every pin entering the core clock domain.
// Assumes pins change slowly against the core clock.
`default_nettype none

module scan_pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] firstStage;

  // The first stage feeds only the second one
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      firstStage <= '0;
      dout <= '0;
    end else begin
      firstStage <= din;
      dout <= firstStage;
    end
  end
endmodule : scan_pin_sync

`default_nettype wire

// File: tap_state_walker.sv
// Test access port state sequencer, advanced on each sampled test clock rise.
// Assumes tckRise is a one-cycle pulse and tms is already synchronised.
`default_nettype none

module tap_state_walker (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic tckRise,
  input wire logic tms,
  output transceiver_scan_pkg::tap_state_t state
);
  import transceiver_scan_pkg::*;

  tap_state_t next_state;

  // Standard sixteen-state walk steered by tms
  always_comb begin
    case (state)
      TAP_RESET: next_state = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: next_state = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: next_state = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: next_state = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: next_state = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: next_state = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: next_state = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: next_state = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: next_state = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: next_state = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: next_state = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: next_state = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: next_state = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: next_state = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: next_state = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: next_state = tms ? TAP_SEL_DR : TAP_IDLE;
      default: next_state = TAP_RESET;
    endcase
  end

  // Power-up lands in the reset state, as the pin pull-up would
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= TAP_RESET;
    end else if (tckRise) begin
      state <= next_state;
    end
  end
endmodule : tap_state_walker

`default_nettype wire

// File: jtag_transceiver_scan_registers.sv
// Boundary chain, test-operation selector, bypass bit and opcode decode
// of an octal transceiver with boundary scan, plus the transceiver pins.
// Assumes test pins and bus pins are asynchronous; the test clock is sampled
// by core_clk, which must run well above it (100 ns against 800 ns here).
//
// Notes on behaviour
// R1 - Eighteen-cell chain: eight inputs, eight outputs, direction and enable cells.
// R2 - The chain both drives test values and captures pin and core values.
// R3 - Capture source follows the instruction; idle-state ops may change contents.
// R4 - The test-logic-reset state never alters the chain.
// R5 - Shifting runs from tdi into bit 17 down to bit 0 on tdo.
// R6 - Bit 17 direction, 16 enable, 15..8 inputs, 7..0 outputs.
// R7 - Direction 0: inputs on port B, outputs on A; 1 reverses this.
// R8 - In normal mode the direction cell follows the direction pin.
// R9 - A two-bit selector picks the extra operation for the run-test op; only BCR_TOPSIP (00) acts here, the other codes leave the chain still.
// R10 - Capture leaves the selector unchanged, so its value shifts out.
// R11 - Power-up or test-logic-reset sets the selector to binary 10.
// R12 - A one-bit bypass path links tdi to tdo.
// R13 - The bypass bit captures 0 whenever it is selected.
// R14 - Opcode bit 7 is ignored; only seven bits decode.
// R15 - Opcode picks chain, selector, or bypass for every other value.
// R16 - Opcode picks test mode, modified test mode or normal mode.
// R17 - Opcodes give HIGHZ, CLAMP, SAMPLE/PRELOAD and EXTEST/INTEST.
// R18 - Power-up or test-logic-reset loads all ones into the instruction.
// R19 - Instruction capture loads 10000001.
// R20 - Data update loads shadow cells on the falling clock in update.
// R21 - The enable cell decides drive or float; control cells stay out of ops.
`default_nettype none

module jtag_transceiver_scan_registers (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic dirPin,
  input wire logic outEnN,
  input wire logic [transceiver_scan_pkg::PORT_W-1:0] aIn,
  input wire logic [transceiver_scan_pkg::PORT_W-1:0] bIn,
  output logic tdoOut,
  output logic tdoOe,
  output logic [transceiver_scan_pkg::PORT_W-1:0] aOut,
  output logic aOe,
  output logic [transceiver_scan_pkg::PORT_W-1:0] bOut,
  output logic bOe
);
  import transceiver_scan_pkg::*;

  // Cell i of a group serves port line 8-i, listed from the high bit down
  function automatic logic [PORT_W-1:0] flipLines(input logic [PORT_W-1:0] v);
    logic [PORT_W-1:0] r;
    r = '0;
    for (int i = 0; i < PORT_W; i++) begin
      r[i] = v[PORT_W-1-i];
    end
    return r;
  endfunction : flipLines

  // Which data register the opcode puts in the scan path
  function automatic dr_sel_t selectOf(input logic [OP_W-1:0] op);
    case (op)
      OP_EXTEST, OP_SAMPLE, OP_INTEST, OP_READN, OP_READT, OP_SELFTEST: selectOf = SEL_BSR;
      OP_SCANN, OP_SCANT: selectOf = SEL_BCR;
      default: selectOf = SEL_BYP;
    endcase
  endfunction : selectOf

  // Operating mode implied by the opcode
  function automatic op_mode_t modeOf(input logic [OP_W-1:0] op);
    case (op)
      OP_EXTEST, OP_INTEST, OP_CLAMP, OP_SELF_RUN_OP, OP_READT, OP_TOGGLE, OP_SCANT: modeOf = MODE_TEST;
      OP_HIGHZ: modeOf = MODE_MODTEST;
      default: modeOf = MODE_NORMAL;
    endcase
  endfunction : modeOf

  logic [SYNC_W-1:0] rawPins;
  logic [SYNC_W-1:0] syncPins;
  logic tckS, tmsS, tdiS, dirS, oenS;
  logic [PORT_W-1:0] aS, bS;
  logic tckLast;
  logic tckRise, tckFall;
  tap_state_t tapState;
  logic inTlr;
  logic [IR_W-1:0] irShift;
  logic [IR_W-1:0] irLatch;
  logic [OP_W-1:0] opcode;
  dr_sel_t curSel;
  op_mode_t curMode;
  logic [BSR_W-1:0] bsrShift;
  logic [BSR_W-1:0] bsrShadow;
  logic [BCR_W-1:0] bcrShift;
  logic [BCR_W-1:0] bcrLatch;
  logic bypassBit;
  logic dirEff, oenEff;
  logic [PORT_W-1:0] inPort;
  logic [PORT_W-1:0] coreIn;
  logic [PORT_W-1:0] coreOut;
  logic [BSR_W-1:0] captureValue;
  logic toggleActive;
  logic sampleActive;
  logic bsrUpdates;

  // All asynchronous pins go through one synchroniser bank
  assign rawPins = {tck, tms, tdi, dirPin, outEnN, aIn, bIn};

  scan_pin_sync #(.WIDTH(SYNC_W)) u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .din(rawPins),
    .dout(syncPins)
  );

  assign tckS = syncPins[SY_TCK];
  assign tmsS = syncPins[SY_TMS];
  assign tdiS = syncPins[SY_TDI];
  assign dirS = syncPins[SY_DIR];
  assign oenS = syncPins[SY_OEN];
  assign aS = syncPins[SY_A_HI:SY_A_LO];
  assign bS = syncPins[SY_B_HI:SY_B_LO];

  // Edge finder on the synchronised test clock
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tckLast <= 1'b0;
    end else begin
      tckLast <= tckS;
    end
  end

  assign tckRise = tckS & ~tckLast;
  assign tckFall = ~tckS & tckLast;

  tap_state_walker u_tap (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .tckRise(tckRise),
    .tms(tmsS),
    .state(tapState)
  );

  assign inTlr = (tapState == TAP_RESET);

  // Decode from the held instruction; the top opcode bit is dropped
  assign opcode = irLatch[OP_W-1:0]; // see R14
  assign curSel = selectOf(opcode); // see R15
  assign curMode = modeOf(opcode); // see R16

  // Idle-state operations; the other selector codes hold the chain still
  assign toggleActive = (opcode == OP_TOGGLE) || ((opcode == OP_SELF_RUN_OP) && (bcrLatch == BCR_TOPSIP)); // see R9
  assign sampleActive = (opcode == OP_SELF_RUN_OP) && (bcrLatch == BCR_TOPSIP);
  assign bsrUpdates = (opcode == OP_EXTEST) || (opcode == OP_INTEST) || (opcode == OP_SAMPLE);

  // Direction and enable come from the cells in test mode, from the pins in normal and modified test mode
  assign dirEff = (curMode == MODE_TEST) ? bsrShadow[BIT_DIR] : dirS; // see R8
  assign oenEff = (curMode == MODE_TEST) ? bsrShadow[BIT_OEN] : oenS; // see R21
  assign inPort = dirEff ? aS : bS; // see R7

  // The core is a plain buffer; in test mode the input cells feed it
  assign coreIn = (curMode == MODE_TEST) ? flipLines(bsrShadow[IN_HI:IN_LO]) : inPort; // see R2
  assign coreOut = coreIn;

  // Capture source chosen by the instruction
  always_comb begin
    case (opcode)
      OP_EXTEST, OP_INTEST, OP_SAMPLE: captureValue = {dirS, oenS, flipLines(inPort), flipLines(coreOut)}; // see R3
      OP_SELFTEST: captureValue = ~bsrShadow;
      default: captureValue = bsrShift;
    endcase
  end

  // Instruction shift stage: fixed capture pattern, then shift toward tdo
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irShift <= IR_RESET;
    end else if (tckRise) begin
      if (tapState == TAP_CAP_IR) begin
        irShift <= IR_CAPTURE; // see R19
      end else if (tapState == TAP_SHIFT_IR) begin
        irShift <= {tdiS, irShift[IR_W-1:1]};
      end
    end
  end

  // Instruction latch: reset to bypass, updated on the falling clock
  always_ff @(posedge core_clk) begin
    if (sys_rst || inTlr) begin
      irLatch <= IR_RESET; // see R18
    end else if (tckFall && (tapState == TAP_UPD_IR)) begin
      irLatch <= irShift;
    end
  end

  // Chain shift stages: capture, shift, and the idle toggle and sample ops
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bsrShift <= BSR_RESET;
    end else if (tckRise && !inTlr) begin // see R4
      if ((curSel == SEL_BSR) && (tapState == TAP_CAP_DR)) begin
        bsrShift <= captureValue; // see R3
      end else if ((curSel == SEL_BSR) && (tapState == TAP_SHIFT_DR)) begin
        bsrShift <= {tdiS, bsrShift[BSR_W-1:1]}; // see R5
      end else if ((tapState == TAP_IDLE) && toggleActive) begin
        // Control cells stay out of the toggle and sample operations
        bsrShift[OUT_HI:OUT_LO] <= ~bsrShift[OUT_HI:OUT_LO]; // see R21
        if (sampleActive) begin
          bsrShift[IN_HI:IN_LO] <= flipLines(inPort);
        end
      end
    end
  end

  // Chain shadow cells, loaded on the falling clock
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bsrShadow <= BSR_RESET;
    end else if (tckFall && !inTlr) begin // see R4
      if ((tapState == TAP_UPD_DR) && (curSel == SEL_BSR) && bsrUpdates) begin
        bsrShadow <= bsrShift; // see R20
      end else if ((tapState == TAP_IDLE) && toggleActive) begin
        bsrShadow[OUT_HI:OUT_LO] <= bsrShift[OUT_HI:OUT_LO]; // see R3
        if (sampleActive) begin
          bsrShadow[IN_HI:IN_LO] <= bsrShift[IN_HI:IN_LO];
        end
      end
    end
  end

  // Selector shift stage: capture leaves it alone, so the held value shifts out
  always_ff @(posedge core_clk) begin
    if (sys_rst || inTlr) begin
      bcrShift <= BCR_RESET; // see R11
    end else if (tckRise && (curSel == SEL_BCR) && (tapState == TAP_SHIFT_DR)) begin
      bcrShift <= {tdiS, bcrShift[BCR_W-1:1]}; // see R10
    end
  end

  // Selector latch, updated on the falling clock in data update
  always_ff @(posedge core_clk) begin
    if (sys_rst || inTlr) begin
      bcrLatch <= BCR_RESET; // see R11
    end else if (tckFall && (tapState == TAP_UPD_DR) && (curSel == SEL_BCR)) begin
      bcrLatch <= bcrShift; // see R20
    end
  end

  // Bypass bit has no shadow stage
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bypassBit <= BYPASS_CAPTURE;
    end else if (tckRise && (curSel == SEL_BYP)) begin
      if (tapState == TAP_CAP_DR) begin
        bypassBit <= BYPASS_CAPTURE; // see R13
      end else if (tapState == TAP_SHIFT_DR) begin
        bypassBit <= tdiS; // see R12
      end
    end
  end

  // Test data out changes on the falling clock, driven only while shifting
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tdoOut <= 1'b0;
      tdoOe <= 1'b0;
    end else if (tckFall) begin
      tdoOe <= (tapState == TAP_SHIFT_IR) || (tapState == TAP_SHIFT_DR);
      if (tapState == TAP_SHIFT_IR) begin
        tdoOut <= irShift[0];
      end else begin
        case (curSel)
          SEL_BSR: tdoOut <= bsrShift[0]; // see R5
          SEL_BCR: tdoOut <= bcrShift[0];
          default: tdoOut <= bypassBit; // see R12
        endcase
      end
    end
  end

  // Bus pins: registered so glitches from the decode never reach the board.
  // High-impedance mode floats both ports while the core keeps running.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      aOut <= '0;
      bOut <= '0;
      aOe <= 1'b0;
      bOe <= 1'b0;
    end else begin
      aOe <= !oenEff && !dirEff && (curMode != MODE_MODTEST); // see R17
      bOe <= !oenEff && dirEff && (curMode != MODE_MODTEST); // see R21
      if (curMode == MODE_TEST) begin
        aOut <= flipLines(bsrShadow[OUT_HI:OUT_LO]); // see R6
        bOut <= flipLines(bsrShadow[OUT_HI:OUT_LO]); // see R1
      end else begin
        aOut <= coreOut;
        bOut <= coreOut;
      end
    end
  end
endmodule : jtag_transceiver_scan_registers

`default_nettype wire

// File: jtag_ctrl_model.sv
// External test controller model: walks the test access port from the far side.
// Assumes the bench core clock paces it; tck is 800 ns and parks high between frames.
`default_nettype none

module jtag_ctrl_model (
  input wire logic core_clk,
  input wire logic tdoOut,
  output logic tck,
  output logic tms,
  output logic tdi
);
  timeunit 1ns;
  timeprecision 1ns;

  // Parked levels; tms high keeps the port in its reset state
  initial begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One 800 ns test clock period: four core cycles low, four high.
  // tdo is read late in the high half, where it is settled; the next call's
  // first edge completes the high half, so back-to-back steps keep the period.
  task automatic step(input logic m, input logic d, output logic q);
    @(posedge core_clk);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge core_clk);
    tck <= 1'b1;
    repeat (3) @(posedge core_clk);
    q = tdoOut;
  endtask : step

  // Outside a shift tdi carries no data, so it is toggled rather than held
  task automatic walk(input logic m);
    logic q;
    step(m, ~tdi, q);
  endtask : walk

  // Five high tms periods always reach test-logic-reset, then idle
  task automatic tap_reset();
    repeat (5) walk(1'b1);
    walk(1'b0);
  endtask : tap_reset

  // Idle to idle scan of n bits; bit 0 leaves and enters first
  task automatic scan(input logic ir, input int n, input logic [17:0] din, output logic [17:0] dout);
    logic q;
    dout = '0;
    walk(1'b1);
    if (ir) walk(1'b1);
    walk(1'b0);
    walk(1'b0);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    walk(1'b1);
    walk(1'b0);
  endtask : scan
endmodule : jtag_ctrl_model

`default_nettype wire

// File: jtag_transceiver_scan_registers_properties.sv
// Port-level checker for the scan register block.
// Assumes it is bound to the top module and sees only its ports.
`default_nettype none

module jtag_transceiver_scan_registers_checker (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic tck,
  input wire logic dirPin,
  input wire logic outEnN,
  input wire logic [transceiver_scan_pkg::PORT_W-1:0] aIn,
  input wire logic [transceiver_scan_pkg::PORT_W-1:0] bIn,
  input wire logic tdoOut,
  input wire logic tdoOe,
  input wire logic [transceiver_scan_pkg::PORT_W-1:0] aOut,
  input wire logic aOe,
  input wire logic [transceiver_scan_pkg::PORT_W-1:0] bOut,
  input wire logic bOe
);
  import transceiver_scan_pkg::*;
  logic [3:0] lowAge;
  logic scanned;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // Cycles since tck was last seen high; tdo may only move shortly after a fall
  always_ff @(posedge core_clk) begin
    if (sys_rst || tck) lowAge <= 4'h0;
    else if (lowAge != 4'hF) lowAge <= lowAge + 4'h1;
  end

  // Until the first scan the instruction is the reset one, so the mode is normal
  always_ff @(posedge core_clk) begin
    if (sys_rst) scanned <= 1'b0;
    else if (tdoOe) scanned <= 1'b1;
  end

  a_reset_quiet: assert property ($fell(sys_rst) |-> !tdoOe && !aOe && !bOe && !tdoOut)
    else $error("outputs not quiet out of reset");
  a_single_driver: assert property (!(aOe && bOe))
    else $error("both ports driven at once");
  a_tdo_timing: assert property ($changed(tdoOut) |-> lowAge inside {[2:5]})
    else $error("tdo moved away from a test clock fall");
  a_tdo_enable_timing: assert property ($changed(tdoOe) |-> lowAge inside {[2:5]})
    else $error("tdo enable moved away from a test clock fall");
  a_normal_a_to_b: assert property ((!scanned && !outEnN && dirPin && $stable({dirPin, outEnN, aIn}))[*5]
    |-> bOe && !aOe && bOut == aIn)
    else $error("port B does not follow port A in normal mode");
  a_normal_b_to_a: assert property ((!scanned && !outEnN && !dirPin && $stable({dirPin, outEnN, bIn}))[*5]
    |-> aOe && !bOe && aOut == bIn)
    else $error("port A does not follow port B in normal mode");
  a_normal_isolate: assert property ((!scanned && outEnN && $stable(outEnN))[*5] |-> !aOe && !bOe)
    else $error("port driven while enable pin is high");
  a_pin_latency: assert property (!scanned && $changed(aIn) |=> $stable(bOut))
    else $error("port B reacted too early to port A");
endmodule : jtag_transceiver_scan_registers_checker

bind jtag_transceiver_scan_registers jtag_transceiver_scan_registers_checker props (
  .core_clk(core_clk), .sys_rst(sys_rst), .tck(tck), .dirPin(dirPin), .outEnN(outEnN), .aIn(aIn),
  .bIn(bIn), .tdoOut(tdoOut), .tdoOe(tdoOe), .aOut(aOut), .aOe(aOe), .bOut(bOut), .bOe(bOe));

`default_nettype wire

// File: jtag_transceiver_scan_registers_bench.sv
// Self-checking bench for the scan register block.
// Assumes the controller model owns the test pins; the bench owns reset and bus pins.
`default_nettype none

module jtag_transceiver_scan_registers_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import transceiver_scan_pkg::*;
  logic core_clk, sys_rst, tck, tms, tdi, dirPin, outEnN, tdoOut, tdoOe, aOe, bOe;
  logic [PORT_W-1:0] aIn, bIn, aOut, bOut;
  logic [BSR_W-1:0] got;
  int err_count = 0;
  int n_tests = 0;

  jtag_transceiver_scan_registers uut (.core_clk(core_clk), .sys_rst(sys_rst), .tck(tck), .tms(tms),
    .tdi(tdi), .dirPin(dirPin), .outEnN(outEnN), .aIn(aIn), .bIn(bIn), .tdoOut(tdoOut), .tdoOe(tdoOe),
    .aOut(aOut), .aOe(aOe), .bOut(bOut), .bOe(bOe));
  jtag_ctrl_model ctrl (.core_clk(core_clk), .tdoOut(tdoOut), .tck(tck), .tms(tms), .tdi(tdi));

  // 10 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] seen);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Line 1 sits in the high cell of each group, so port bits appear reversed
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev8[i] = v[7 - i];
  endfunction : rev8

  task automatic do_reset();
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    // Reset leaves the port in test-logic-reset; scans start from idle
    ctrl.walk(1'b0);
  endtask : do_reset

  task automatic pins(input logic d, input logic e, input logic [7:0] a, input logic [7:0] b);
    @(posedge core_clk);
    dirPin <= d;
    outEnN <= e;
    aIn <= a;
    bIn <= b;
    repeat (6) @(posedge core_clk);
  endtask : pins

  task automatic load_ir(input logic [7:0] op);
    ctrl.scan(1'b1, 8, {10'h000, op}, got);
    chk("ir capture", {10'h000, IR_CAPTURE}, got);
  endtask : load_ir

  task automatic t_normal();
    pins(1'b1, 1'b1, 8'hA5, 8'h3C);
    chk("isolate", 2'b00, {aOe, bOe});
    pins(1'b0, 1'b0, 8'hA5, 8'h3C);
    chk("b to a", {2'b10, 8'h3C}, {aOe, bOe, aOut});
    pins(1'b1, 1'b0, 8'hA5, 8'h3C);
    chk("a to b", {2'b01, 8'hA5}, {aOe, bOe, bOut});
  endtask : t_normal

  // Unlisted opcodes and bypass-path instructions, some with bit 7 set
  task automatic t_bypass();
    logic [7:0] ops [7] = '{8'h01, 8'h05, 8'h7F, 8'h86, 8'h87, 8'h89, 8'h8D};
    ctrl.scan(1'b0, 2, 18'h00003, got);
    chk("reset bypass", 18'h00002, got);
    foreach (ops[i]) begin
      load_ir(ops[i]);
      if (ops[i] == 8'h86) chk("highz oe", 2'b00, {aOe, bOe});
      ctrl.scan(1'b0, 2, 18'h00003, got);
      chk("bypass", 18'h00002, got);
    end
  endtask : t_bypass

  task automatic t_selector();
    load_ir(8'h8E);
    ctrl.scan(1'b0, 2, 18'h00001, got);
    chk("selector reset", {16'h0000, BCR_RESET}, got);
    ctrl.scan(1'b0, 2, 18'h00000, got);
    chk("selector hold", 18'h00001, got);
    load_ir(8'h0F);
    ctrl.scan(1'b0, 2, 18'h00003, got);
    chk("selector test", 18'h00000, got);
  endtask : t_selector

  task automatic t_chain();
    load_ir(8'h02);
    ctrl.scan(1'b0, 18, {10'h000, 8'h5C}, got);
    chk("sample", {2'b10, rev8(8'hA5), rev8(8'hA5)}, got);
    load_ir(8'h00);
    chk("extest a", {2'b10, rev8(8'h5C)}, {aOe, bOe, aOut});
    ctrl.scan(1'b0, 18, {10'h200, 8'hC3}, got);
    chk("extest in", rev8(8'h3C), got[15:8]);
    chk("extest b", {2'b01, rev8(8'hC3)}, {aOe, bOe, bOut});
    load_ir(8'h06);
    chk("highz", 2'b00, {aOe, bOe});
    load_ir(8'h07);
    chk("clamp", {2'b01, rev8(8'hC3)}, {aOe, bOe, bOut});
    load_ir(8'h0C);
    ctrl.scan(1'b0, 18, 18'h2AAAA, got);
    chk("self test", ~{10'h200, 8'hC3}, got);
  endtask : t_chain

  task automatic t_tlr();
    ctrl.tap_reset();
    load_ir(8'h0A);
    ctrl.scan(1'b0, 18, 18'h00000, got);
    chk("chain after tlr", 18'h2AAAA, got);
    load_ir(8'h0E);
    ctrl.scan(1'b0, 2, 18'h00000, got);
    chk("selector after tlr", {16'h0000, BCR_RESET}, got);
  endtask : t_tlr

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  // Main sequence, with a second reset in mid-run
  initial begin
    sys_rst <= 1'b1;
    dirPin <= 1'b0;
    outEnN <= 1'b1;
    aIn <= 8'h00;
    bIn <= 8'h00;
    do_reset();
    t_normal();
    t_bypass();
    t_selector();
    t_chain();
    t_tlr();
    do_reset();
    ctrl.scan(1'b0, 2, 18'h00001, got);
    chk("bypass after reset", 18'h00002, got);
    give_verdict();
  end

  // The run needs about 0.34 ms; six times that means a hang
  initial begin
    #2000000;
    err_count++;
    give_verdict();
  end
endmodule : jtag_transceiver_scan_registers_bench

`default_nettype wire
